// >>> sim/flash_secure_range_and_crc_test.sv
// Self-checking bench for fsc_top over its Wishbone port.
// Assumes the bench plays the flash word port, one word in flight.
`timescale 1ns/100ps
module flash_secure_range_and_crc_test;
    logic        sys_clk;
    logic        rst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        flash_rd_req;
    logic [19:0] flash_rd_addr;
    logic        flash_rd_valid;
    logic [31:0] flash_rd_data;
    logic [9:0]  end_s;
    logic [10:0] data_s;
    logic [10:0] first_s;
    logic        has_data;
    logic        fault;
    logic        unlocked;
    logic        busy;
    logic [31:0] rd;
    logic [31:0] crc_exp;
    logic [19:0] exp_addr;
    int          words;
    int          addr_bad;
    int          miscompares;
    int          tests_run;
    logic [31:0] rng [3] = '{32'h7FFFF9FF, 32'h00000000, 32'h00C00802};
    logic [31:0] flg [3] = '{32'h2, 32'hE, 32'hA};

    fsc_top i_fsc_top
    (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
        .flash_rd_data(flash_rd_data), .protected_end_sector(end_s),
        .protected_data_first_sector(data_s),
        .protected_first_sector(first_s),
        .protected_has_data_area(has_data),
        .protected_start_fault(fault),
        .settings_unlocked_flag(unlocked), .checksum_busy(busy)
    );

    // ------------------------------------------------------------
    // Clock, flash responder and helpers
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
            c = (c[31] ^ d[i]) ? {c[30:0], 1'b0} ^ fsc_pkg::FSC_CRC_POLY
                               : {c[30:0], 1'b0};
        return c;
    endfunction

    // Idle data is inverted each cycle so a stale word never looks valid
    always @(posedge sys_clk)
    begin
        flash_rd_valid <= flash_rd_req === 1'b1 && flash_rd_valid !== 1'b1;
        flash_rd_data <= (flash_rd_req === 1'b1 && flash_rd_valid !== 1'b1)
                         ? {~flash_rd_addr[11:0], flash_rd_addr}
                         : ~flash_rd_data;
        if (flash_rd_req === 1'b1 && flash_rd_valid === 1'b1)
        begin
            if (flash_rd_addr !== exp_addr)
                addr_bad++;
            exp_addr <= exp_addr + 20'h1;
            crc_exp <= crc_step(crc_exp, flash_rd_data);
            words++;
        end
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [3:0] sel, input logic [31:0] dat);
        int n;
        logic ok;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        ok = (wb_ack_o === 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
        check({31'h0, !ok}, 32'h0, "bus timeout");
        if (!ok)
            test_done();
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, busy !== 1'b0}, 32'h0, "run timeout");
        if (busy !== 1'b0)
            test_done();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, flash_rd_valid} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, flash_rd_data} = '0;
        {miscompares, tests_run, words, addr_bad} = '0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check({end_s, data_s, first_s}, 32'h0, "reset fields");
        check({has_data, fault, unlocked, busy}, 32'hC, "reset flags");
        wb(1'b0, 8'h0C, 4'hF, 32'h0);
        check(rd, 32'h00000000, "reset result");
        $display("reset test done");

        wb(1'b1, 8'h00, 4'hF, rng[0]);
        check({end_s, data_s, first_s}, 32'h0, "locked range");
        wb(1'b1, 8'h04, 4'hF, 32'hA35F6D25);
        check(unlocked, 32'h0, "wrong key");
        wb(1'b1, 8'h04, 4'h7, fsc_pkg::FSC_UNLOCK_KEY);
        check(unlocked, 32'h0, "partial key");
        wb(1'b1, 8'h04, 4'hF, fsc_pkg::FSC_UNLOCK_KEY);
        check(unlocked, 32'h1, "unlock flag");
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        check(rd, 32'h0, "key read");
        wb(1'b0, 8'h10, 4'hF, 32'h0);
        check(rd, 32'h6, "status read");
        wb(1'b0, 8'h20, 4'hF, 32'h0);
        check(rd, 32'h0, "unmapped read");
        $display("unlock test done");

        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, 8'h00, 4'hF, rng[i]);
            check({end_s, data_s, first_s}, rng[i], "range");
            check({has_data, fault, unlocked, busy}, flg[i], "area");
            wb(1'b0, 8'h00, 4'hF, 32'h0);
            check(rd, 32'h0, "range read");
        end
        wb(1'b1, 8'h00, 4'hE, 32'h0);
        check({end_s, data_s, first_s}, rng[2], "partial range");
        $display("range test done");

        crc_exp = fsc_pkg::FSC_CRC_INIT;
        exp_addr = 20'd1024;
        wb(1'b1, 8'h08, 4'hF, 32'h80001002);
        wb(1'b1, 8'h08, 4'hF, 32'h80001007);
        wait_idle();
        check(words, 32'd512, "word count");
        check(addr_bad, 32'd0, "word addresses");
        wb(1'b0, 8'h0C, 4'hF, 32'h0);
        check(rd, crc_exp ^ fsc_pkg::FSC_CRC_XOR_OUT, "result");
        wb(1'b0, 8'h08, 4'hF, 32'h0);
        check(rd, 32'h0, "control read");
        wb(1'b1, 8'h08, 4'hF, 32'h80000000);
        wait_idle();
        wb(1'b0, 8'h0C, 4'hF, 32'h0);
        check(rd, 32'h00000000, "empty run result");
        $display("checksum test done");
        test_done();
    end
endmodule

// >>> sim/fsc_top_asserts.sv
// Checker for the register side and range outputs of fsc_top.
// Assumes it is bound to fsc_top and sees only that module's ports.
`timescale 1ns/100ps
module fsc_top_asserts
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        flash_rd_req,
    input wire logic [9:0]  protected_end_sector,
    input wire logic [10:0] protected_data_first_sector,
    input wire logic [10:0] protected_first_sector,
    input wire logic        protected_has_data_area,
    input wire logic        protected_start_fault,
    input wire logic        settings_unlocked_flag,
    input wire logic        checksum_busy
);
    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic take;
    logic wr;
    logic key_wr;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i == fsc_pkg::FSC_SEL_ALL;
    assign key_wr = wr && wb_adr_i == fsc_pkg::FSC_OFF_UNLOCK
                    && wb_dat_i == fsc_pkg::FSC_UNLOCK_KEY;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    ack_single_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a one-cycle answer");
    wo_read_zero_a:
        assert property (take && !wb_we_i && wb_adr_i <= 8'h08
            |=> wb_dat_o == 32'h00000000) else $error("wo read not zero");
    locked_range_a:
        assert property (wr && wb_adr_i == 8'h00 && !settings_unlocked_flag
            |=> $stable(protected_end_sector)
            && $stable(protected_data_first_sector)
            && $stable(protected_first_sector))
        else $error("locked range write took effect");
    range_write_a:
        assert property (wr && wb_adr_i == 8'h00 && settings_unlocked_flag
            |=> protected_end_sector == $past(wb_dat_i[31:22])
            && protected_data_first_sector == $past(wb_dat_i[21:11])
            && protected_first_sector == $past(wb_dat_i[10:0]))
        else $error("range fields not taken");
    no_data_area_a:
        assert property (protected_has_data_area
            == (protected_data_first_sector != 11'h7FF))
        else $error("data area flag wrong");
    start_fault_a:
        assert property (protected_start_fault
            == (protected_data_first_sector == 11'h000))
        else $error("start fault flag wrong");
    unlock_set_a: assert property (key_wr |=> settings_unlocked_flag)
        else $error("key did not unlock");
    unlock_cause_a:
        assert property ($rose(settings_unlocked_flag) |-> $past(key_wr))
        else $error("unlock flag rose without key");
    launch_busy_a:
        assert property (wr && wb_adr_i == 8'h08 && wb_dat_i[31]
            && !checksum_busy |=> checksum_busy)
        else $error("launch did not start checksum");
    read_in_run_a: assert property (flash_rd_req |-> checksum_busy)
        else $error("flash read outside a run");
endmodule

bind fsc_top fsc_top_asserts i_fsc_top_asserts
(
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_rd_req(flash_rd_req),
    .protected_end_sector(protected_end_sector),
    .protected_data_first_sector(protected_data_first_sector),
    .protected_first_sector(protected_first_sector),
    .protected_has_data_area(protected_has_data_area),
    .protected_start_fault(protected_start_fault),
    .settings_unlocked_flag(settings_unlocked_flag),
    .checksum_busy(checksum_busy)
);

// >>> src/fsc_crc.sv
// Running 32-bit checksum over one data word per cycle.
// Assumes words arrive on the same clock; msb of each word goes first.
`timescale 1ns/100ps
module fsc_crc
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        word_valid,
    input  wire logic [31:0] word_data,
    output logic      [31:0] crc
);
    logic [31:0] crc_r;
    logic [31:0] crc_nxt;
    logic [31:0] step;

    always_comb
    begin
        step = crc_r;
        for (int i = 31; i >= 0; i--)
        begin
            if (step[31] ^ word_data[i])
                step = {step[30:0], 1'b0} ^ fsc_pkg::FSC_CRC_POLY;
            else
                step = {step[30:0], 1'b0};
        end
        if (clear)
            crc_nxt = fsc_pkg::FSC_CRC_INIT;
        else if (word_valid)
            crc_nxt = step;
        else
            crc_nxt = crc_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            crc_r <= fsc_pkg::FSC_CRC_INIT;
        else
            crc_r <= crc_nxt;
    end

    assign crc = crc_r;
endmodule

// >>> src/fsc_pkg.sv
// Constants shared by the secure range and sector checksum block.
// Assumes a classic Wishbone master and a same-clock flash word port.
//
// What this block does
// R01 - Write-only end sector field, bits 31:22, sector 0 to 511.
// R02 - Write-only data first sector field, bits 21:11; zero means the library fails.
// R03 - All ones in data first sector means no data area; 1 to 511 pick sector.
// R04 - Write-only first sector field, bits 10:0, sector 0 to 511.
// R05 - Range register reads return zero whatever was written.
// R06 - Range writes are taken only after the settings are unlocked.
// R07 - Writing the fixed key unlocks settings; the key register reads zero.
// R08 - A read-only flag, status bit 2, shows the settings are unlocked.
// R09 - Writing one to control bit 31 launches a checksum; the bit self-clears.
// R10 - Control bits 23:12 give the number of sectors to cover.
// R11 - Control bits 11:0 give the first sector, counted from zero.
// R12 - The 32-bit checksum lands in the result register and holds until the next.
package fsc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FSC_OFF_RANGE  = 8'h00;
    localparam logic [7:0] FSC_OFF_UNLOCK = 8'h04;
    localparam logic [7:0] FSC_OFF_CTRL   = 8'h08;
    localparam logic [7:0] FSC_OFF_RESULT = 8'h0C;
    localparam logic [7:0] FSC_OFF_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FSC_END_MSB    = 31;
    localparam int FSC_END_LSB    = 22;
    localparam int FSC_DATA_MSB   = 21;
    localparam int FSC_DATA_LSB   = 11;
    localparam int FSC_FIRST_MSB  = 10;
    localparam int FSC_FIRST_LSB  = 0;
    localparam int FSC_LAUNCH_BIT = 31;
    localparam int FSC_CNT_MSB    = 23;
    localparam int FSC_CNT_LSB    = 12;
    localparam int FSC_CSS_MSB    = 11;
    localparam int FSC_CSS_LSB    = 0;
    localparam int FSC_ST_BUSY    = 0;
    localparam int FSC_ST_BADDATA = 1;
    localparam int FSC_ST_UNLOCK  = 2;

    // ------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] FSC_UNLOCK_KEY   = 32'hA35F6D24;
    localparam logic [10:0] FSC_NO_DATA_AREA = 11'h7FF;
    localparam logic [10:0] FSC_SECTOR_RST   = 11'h000;
    localparam logic [11:0] FSC_CRC_FLD_RST  = 12'h000;
    localparam logic [31:0] FSC_RESULT_RST   = 32'h00000000;
    localparam logic [31:0] FSC_CRC_POLY     = 32'h04C11DB7;
    localparam logic [31:0] FSC_CRC_INIT     = 32'hFFFFFFFF;
    localparam logic [31:0] FSC_CRC_XOR_OUT  = 32'hFFFFFFFF;
    localparam logic [3:0]  FSC_SEL_ALL      = 4'hF;

endpackage

// >>> src/fsc_top.sv
// Secure library range settings, unlock key and sector checksum.
// Assumes a classic Wishbone master on sys_clk and a flash word read
// port on the same clock; range outputs feed the flash controller.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module fsc_top
#(
    parameter int ADDR_W          = 20,
    parameter int SECT_WORDS_LOG2 = 9
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Flash word read port
    output logic                   flash_rd_req,
    output logic      [ADDR_W-1:0] flash_rd_addr,
    input  wire logic              flash_rd_valid,
    input  wire logic [31:0]       flash_rd_data,
    // Range settings toward the flash controller
    output logic      [9:0]        protected_end_sector,
    output logic      [10:0]       protected_data_first_sector,
    output logic      [10:0]       protected_first_sector,
    output logic                   protected_has_data_area,
    output logic                   protected_start_fault,
    output logic                   settings_unlocked_flag,
    output logic                   checksum_busy
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    logic        req;
    logic        wr_full;
    logic        wr_range;
    logic        wr_unlock;
    logic        wr_ctrl;

    // Request is taken on the first cycle; ack answers one cycle later
    assign req     = wb_cyc_i && wb_stb_i && !ack_r;
    // Partial-lane writes are acknowledged but do not change state,
    // since a key or a sector field split over lanes makes no sense
    assign wr_full   = req && wb_we_i && (wb_sel_i == fsc_pkg::FSC_SEL_ALL);
    assign wr_range  = wr_full && (wb_adr_i == fsc_pkg::FSC_OFF_RANGE);
    assign wr_unlock = wr_full && (wb_adr_i == fsc_pkg::FSC_OFF_UNLOCK);
    assign wr_ctrl   = wr_full && (wb_adr_i == fsc_pkg::FSC_OFF_CTRL);

    // ------------------------------------------------------------
    // Unlock flag
    // ------------------------------------------------------------
    // Set by the key and held; reset is the only way back
    logic unlock_r;
    logic unlock_nxt;

    always_comb
    begin
        unlock_nxt = unlock_r;

        // Only the exact key opens the settings; it stays open to reset
        if (wr_unlock && (wb_dat_i == fsc_pkg::FSC_UNLOCK_KEY)) // R07
            unlock_nxt = 1'b1; // R08
    end

    // No relock path: a wrong key later cannot close it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            unlock_r <= 1'b0;
        else
            unlock_r <= unlock_nxt;
    end

    // ------------------------------------------------------------
    // Range settings
    // ------------------------------------------------------------
    // Widths follow the fields; values above 511 are stored as written
    logic [9:0]  end_sec_r;
    logic [9:0]  end_sec_nxt;
    logic [10:0] data_sec_r;
    logic [10:0] data_sec_nxt;
    logic [10:0] first_sec_r;
    logic [10:0] first_sec_nxt;

    always_comb
    begin
        end_sec_nxt   = end_sec_r;
        data_sec_nxt  = data_sec_r;
        first_sec_nxt = first_sec_r;

        // Locked writes are acknowledged and dropped
        if (wr_range && unlock_r) // R06
        begin
            end_sec_nxt   = wb_dat_i[fsc_pkg::FSC_END_MSB:
                                     fsc_pkg::FSC_END_LSB]; // R01
            data_sec_nxt  = wb_dat_i[fsc_pkg::FSC_DATA_MSB:
                                     fsc_pkg::FSC_DATA_LSB]; // R02
            first_sec_nxt = wb_dat_i[fsc_pkg::FSC_FIRST_MSB:
                                     fsc_pkg::FSC_FIRST_LSB]; // R04
        end
    end

    // Zero data field after reset reads as a start fault
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            end_sec_r   <= 10'h000;
            data_sec_r  <= fsc_pkg::FSC_SECTOR_RST;
            first_sec_r <= fsc_pkg::FSC_SECTOR_RST;
        end
        else
        begin
            end_sec_r   <= end_sec_nxt;
            data_sec_r  <= data_sec_nxt;
            first_sec_r <= first_sec_nxt;
        end
    end

    assign protected_end_sector        = end_sec_r;
    assign protected_data_first_sector = data_sec_r;
    assign protected_first_sector      = first_sec_r;
    // All ones in the data field means no data area at all
    assign protected_has_data_area     =
        (data_sec_r != fsc_pkg::FSC_NO_DATA_AREA); // R03
    // Zero is never a valid data sector, so startup must fail
    assign protected_start_fault       =
        (data_sec_r == fsc_pkg::FSC_SECTOR_RST); // R02
    assign settings_unlocked_flag      = unlock_r; // R08

    // ------------------------------------------------------------
    // Checksum control
    // ------------------------------------------------------------
    logic [11:0] ccount_r;
    logic [11:0] ccount_nxt;
    logic [11:0] cfirst_r;
    logic [11:0] cfirst_nxt;
    logic        launch_r;
    logic        launch_nxt;

    logic        walk_busy;
    logic        walk_done;
    logic        word_valid;
    logic [31:0] word_data;
    logic [31:0] crc;

    always_comb
    begin
        ccount_nxt = ccount_r;
        cfirst_nxt = cfirst_r;

        // Launch bit lives one cycle, then clears itself
        launch_nxt = 1'b0; // R09
        if (wr_ctrl)
        begin
            ccount_nxt = wb_dat_i[fsc_pkg::FSC_CNT_MSB:
                                  fsc_pkg::FSC_CNT_LSB]; // R10
            cfirst_nxt = wb_dat_i[fsc_pkg::FSC_CSS_MSB:
                                  fsc_pkg::FSC_CSS_LSB]; // R11
            // A launch while a run is active is ignored
            launch_nxt = wb_dat_i[fsc_pkg::FSC_LAUNCH_BIT]
                         && !walk_busy && !launch_r; // R09
        end
    end

    // Fields persist after a run; only a write changes them
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ccount_r <= fsc_pkg::FSC_CRC_FLD_RST;
            cfirst_r <= fsc_pkg::FSC_CRC_FLD_RST;
            launch_r <= 1'b0;
        end
        else
        begin
            ccount_r <= ccount_nxt;
            cfirst_r <= cfirst_nxt;
            launch_r <= launch_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checksum engine
    // ------------------------------------------------------------
    // The walker fetches words and the checksum unit folds them in
    fsc_walk
    #(
        .ADDR_W          (ADDR_W),
        .SECT_WORDS_LOG2 (SECT_WORDS_LOG2)
    )
    i_fsc_walk
    (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .go           (launch_r),
        .first_sector (cfirst_r),
        .sector_count (ccount_r),
        .rd_req       (flash_rd_req),
        .rd_addr      (flash_rd_addr),
        .rd_valid     (flash_rd_valid),
        .rd_data      (flash_rd_data),
        .word_valid   (word_valid),
        .word_data    (word_data),
        .done         (walk_done),
        .busy         (walk_busy)
    );

    // Seeded by the launch pulse, on the edge the walker starts
    fsc_crc
    i_fsc_crc
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clear      (launch_r),
        .word_valid (word_valid),
        .word_data  (word_data),
        .crc        (crc)
    );

    // ------------------------------------------------------------
    // Checksum result
    // ------------------------------------------------------------
    // Written only at the end of a run
    logic [31:0] result_r;
    logic [31:0] result_nxt;

    always_comb
    begin
        result_nxt = result_r;

        // Old value stays readable during a run
        if (walk_done)
            result_nxt = crc ^ fsc_pkg::FSC_CRC_XOR_OUT; // R12
    end

    // Reset value equals an empty run's result, so zero is ambiguous
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            result_r <= fsc_pkg::FSC_RESULT_RST;
        else
            result_r <= result_nxt;
    end

    // Busy covers the launch cycle, before the walker moves
    assign checksum_busy = walk_busy || launch_r;

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_comb
    begin
        ack_nxt  = req;
        rdat_nxt = 32'h00000000;

        if (req && !wb_we_i)
        begin
            // Range, key and control read as zero; unmapped reads zero
            unique case (wb_adr_i)
                fsc_pkg::FSC_OFF_RESULT:
                    rdat_nxt = result_r; // R12
                fsc_pkg::FSC_OFF_STATUS:
                begin
                    rdat_nxt[fsc_pkg::FSC_ST_UNLOCK]  = unlock_r; // R08
                    rdat_nxt[fsc_pkg::FSC_ST_BUSY]    = checksum_busy;
                    rdat_nxt[fsc_pkg::FSC_ST_BADDATA] = protected_start_fault;
                end
                default:
                    rdat_nxt = 32'h00000000; // R05
            endcase
        end
    end

    // Data falls back to zero once the answer cycle is over
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h00000000;
        end
        else
        begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // One wait state on every access, reads and writes alike
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
endmodule

// >>> src/fsc_walk.sv
// Walks the flash words of a run of sectors, one read in flight.
// Assumes the flash port answers rd_valid for one cycle per request.
`timescale 1ns/100ps
module fsc_walk
#(
    parameter int ADDR_W      = 20,
    parameter int SECT_WORDS_LOG2 = 9
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              go,
    input  wire logic [11:0]       first_sector,
    input  wire logic [11:0]       sector_count,
    output logic                   rd_req,
    output logic      [ADDR_W-1:0] rd_addr,
    input  wire logic              rd_valid,
    input  wire logic [31:0]       rd_data,
    output logic                   word_valid,
    output logic      [31:0]       word_data,
    output logic                   done,
    output logic                   busy
);
    localparam int LEN_W = 12 + SECT_WORDS_LOG2;

    typedef enum {FSC_IDLE, FSC_READ, FSC_DONE} fsc_walk_e;

    fsc_walk_e         state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [LEN_W-1:0]  left_r, left_nxt;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        addr_nxt  = addr_r;
        left_nxt  = left_r;
        unique case (state_r)
            FSC_IDLE:
            begin
                if (go)
                begin
                    addr_nxt  = ADDR_W'({first_sector,
                                         {SECT_WORDS_LOG2{1'b0}}});
                    left_nxt  = {sector_count, {SECT_WORDS_LOG2{1'b0}}};
                    // A zero count finishes at once with the seed value
                    state_nxt = (sector_count == 12'h000) ? FSC_DONE
                                                          : FSC_READ;
                end
            end
            FSC_READ:
            begin
                if (rd_valid)
                begin
                    addr_nxt = addr_r + ADDR_W'(1);
                    left_nxt = left_r - LEN_W'(1);
                    if (left_r == LEN_W'(1))
                        state_nxt = FSC_DONE;
                end
            end
            FSC_DONE:
                state_nxt = FSC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= FSC_IDLE;
            addr_r  <= '0;
            left_r  <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            left_r  <= left_nxt;
        end
    end

    assign rd_req     = (state_r == FSC_READ);
    assign rd_addr    = addr_r;
    assign word_valid = (state_r == FSC_READ) && rd_valid;
    assign word_data  = rd_data;
    assign done       = (state_r == FSC_DONE);
    assign busy       = (state_r != FSC_IDLE);
endmodule
